// [plbc_pkg.sv]
// constants, field positions and carrier types of the led and transceiver control bank
package plbc_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned STRETCH_TIME_MS = 50;
    localparam int unsigned STRETCH_CYCLES = (STRETCH_TIME_MS * (CLK_HZ / 1000));
    localparam int unsigned STRAP_SETTLE_CYCLES = 2;

    // ****************************************
    // register map
    // ****************************************
    localparam int unsigned REG_ADDR_W = 5;
    localparam int unsigned REG_DATA_W = 16;
    localparam logic [4:0] LED_OVERRIDE_CONTROL_ADDR = 5'h18;
    localparam logic [4:0] TRANSCEIVER_CONTROL_ADDR = 5'h19;
    localparam logic [15:0] REG_ZERO = 16'h0000;

    // led override control fields
    localparam int unsigned LOC_SPEED_EN_BIT = 5;
    localparam int unsigned LOC_LINK_EN_BIT = 4;
    localparam int unsigned LOC_ACT_EN_BIT = 3;
    localparam int unsigned LOC_SPEED_VAL_BIT = 2;
    localparam int unsigned LOC_LINK_VAL_BIT = 1;
    localparam int unsigned LOC_ACT_VAL_BIT = 0;
    localparam logic [2:0] LED_RESET = 3'h0;

    // transceiver control fields
    localparam int unsigned TC_AUTO_XOVER_BIT = 15;
    localparam int unsigned TC_FORCE_XOVER_BIT = 14;
    localparam int unsigned TC_PAUSE_RX_BIT = 13;
    localparam int unsigned TC_PAUSE_TX_BIT = 12;
    localparam int unsigned TC_INJECT_ERR_BIT = 11;
    localparam int unsigned TC_SEQ_SEL_BIT = 10;
    localparam int unsigned TC_PASS_BIT = 9;
    localparam int unsigned TC_RUN_BIT = 8;
    localparam int unsigned TC_STRETCH_BYP_BIT = 7;

    // pause advertisement fields, as bits 11:10 of the ability words
    localparam int unsigned ADV_SYM_PAUSE_BIT = 0;
    localparam int unsigned ADV_ASYM_DIR_BIT = 1;

    // one bit per led
    typedef struct packed {
        logic speed;
        logic link;
        logic activity;
    } plbc_led_t;

endpackage

// [plbc_led_stretch.sv]
// pulse stretcher for the three led indications with raw bypass
`timescale 1ns/10ps
module plbc_led_stretch #(
    parameter int unsigned STRETCH_CYCLES = plbc_pkg::STRETCH_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic bypass_i,
    // indications
    input wire plbc_pkg::plbc_led_t raw_i,
    output plbc_pkg::plbc_led_t led_o
);

    localparam int unsigned CNT_W = $clog2(STRETCH_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(STRETCH_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    logic [2:0] raw_vec;
    logic [2:0] out_vec;

    assign raw_vec = raw_i;
    assign led_o = out_vec;

    // ****************************************
    // one stretch counter per led
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_led
            logic [CNT_W-1:0] cnt_reg;
            logic out_reg;

            // a short blip keeps the led lit for the whole stretch so the eye can see it
            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    cnt_reg <= CNT_ZERO;
                end else if (raw_vec[g]) begin
                    cnt_reg <= CNT_LOAD;
                end else if (cnt_reg != CNT_ZERO) begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end

            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    out_reg <= 1'b0;
                end else if (bypass_i) begin
                    out_reg <= raw_vec[g];
                end else begin
                    out_reg <= raw_vec[g] | (cnt_reg != CNT_ZERO);
                end
            end

            assign out_vec[g] = out_reg;
        end
    endgenerate

endmodule // plbc_led_stretch

// [plbc_led_xover_bist_regs.sv]
// led override and transceiver control registers with led, crossover, pause and self-test logic
//
// Contract
// - led override bits 15:6 read zero, ignore writes
// - led register reads stored bits, not pins
// - bit 5 forces speed led from bit 2
// - bit 4 forces link led from bit 1
// - bit 3 forces activity led from bit 0
// - bit 15 auto crossover, reset from strap
// - bit 14 forces crossed line pairs
// - bit 13 resolved pause receive result
// - bit 12 resolved pause transmit result
// - pause results only for full duplex
// - bit 11 injects one error, self-clears
// - bit 9 pass, fail latched until stop
// - no error tally held here
// - bit 7 bypasses led stretching
`timescale 1ns/10ps
module plbc_led_xover_bist_regs #(
    parameter int unsigned STRETCH_CYCLES = plbc_pkg::STRETCH_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // management register port
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // strap pin
    input wire logic auto_crossover_strap_i,
    // normal led indications
    input wire plbc_pkg::plbc_led_t led_normal_i,
    // led pins
    output logic speed_led_out_o,
    output logic link_led_out_o,
    output logic activity_collision_led_out_o,
    // auto-negotiation results
    input wire logic [1:0] local_pause_adv_i,
    input wire logic [1:0] partner_pause_adv_i,
    input wire logic an_full_duplex_i,
    // crossover control
    output logic auto_crossover_en_o,
    output logic force_crossover_o,
    // self-test engine
    input wire logic selftest_error_i,
    output logic selftest_run_o,
    output logic selftest_sequence_select_o,
    output logic selftest_inject_error_o,
    // pause results for the mac
    output logic pause_rx_en_o,
    output logic pause_tx_en_o
);

    // ****************************************
    // declarations
    // ****************************************
    logic wr_led;
    logic wr_tc;
    logic [2:0] led_en_reg;
    logic [2:0] led_val_reg;
    logic strap_meta_reg;
    logic strap_sync_reg;
    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;
    logic auto_crossover_en_reg;
    logic force_crossover_reg;
    logic inject_reg;
    logic seq_sel_reg;
    logic run_reg;
    logic fail_reg;
    logic pass_flag;
    logic bypass_reg;
    logic pause_rx_next;
    logic pause_tx_next;
    logic pause_rx_reg;
    logic pause_tx_reg;
    logic [15:0] led_word;
    logic [15:0] tc_word;
    logic [15:0] rdata_next;
    plbc_pkg::plbc_led_t stretched;
    plbc_pkg::plbc_led_t led_out_next;
    plbc_pkg::plbc_led_t led_out_reg;

    assign wr_led = reg_wr_i && (reg_addr_i == plbc_pkg::LED_OVERRIDE_CONTROL_ADDR);
    assign wr_tc = reg_wr_i && (reg_addr_i == plbc_pkg::TRANSCEIVER_CONTROL_ADDR);

    // ****************************************
    // led override control
    // ****************************************
    // only bits 5:0 are stored; the upper bits have no storage at all
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            led_en_reg <= plbc_pkg::LED_RESET;
            led_val_reg <= plbc_pkg::LED_RESET;
        end else if (wr_led) begin
            led_en_reg <= {reg_wdata_i[plbc_pkg::LOC_SPEED_EN_BIT], reg_wdata_i[plbc_pkg::LOC_LINK_EN_BIT],
                           reg_wdata_i[plbc_pkg::LOC_ACT_EN_BIT]};
            led_val_reg <= {reg_wdata_i[plbc_pkg::LOC_SPEED_VAL_BIT], reg_wdata_i[plbc_pkg::LOC_LINK_VAL_BIT],
                            reg_wdata_i[plbc_pkg::LOC_ACT_VAL_BIT]};
        end
    end

    // ****************************************
    // led path
    // ****************************************
    plbc_led_stretch #(
        .STRETCH_CYCLES(STRETCH_CYCLES)
    ) u_stretch (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .bypass_i(bypass_reg),
        .raw_i(led_normal_i),
        .led_o(stretched)
    );

    // override acts after stretching so a forced value shows without delay
    always_comb begin
        led_out_next.speed = led_en_reg[2] ? led_val_reg[2] : stretched.speed;
        led_out_next.link = led_en_reg[1] ? led_val_reg[1] : stretched.link;
        led_out_next.activity = led_en_reg[0] ? led_val_reg[0] : stretched.activity;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            led_out_reg <= '0;
        end else begin
            led_out_reg <= led_out_next;
        end
    end

    assign speed_led_out_o = led_out_reg.speed;
    assign link_led_out_o = led_out_reg.link;
    assign activity_collision_led_out_o = led_out_reg.activity;

    // ****************************************
    // strap capture
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_meta_reg <= 1'b0;
            strap_sync_reg <= 1'b0;
        end else begin
            strap_meta_reg <= auto_crossover_strap_i;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // wait for the synchroniser to fill before trusting the strap level
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 1'b1;
            strap_done_reg <= (strap_cnt_reg == 2'(plbc_pkg::STRAP_SETTLE_CYCLES));
        end
    end

    // ****************************************
    // crossover control
    // ****************************************
    // a software write in the strap load cycle wins; a write earlier in the strap window is overwritten when the strap loads
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            auto_crossover_en_reg <= 1'b0;
        end else if (wr_tc) begin
            auto_crossover_en_reg <= reg_wdata_i[plbc_pkg::TC_AUTO_XOVER_BIT];
        end else if (!strap_done_reg && (strap_cnt_reg == 2'(plbc_pkg::STRAP_SETTLE_CYCLES))) begin
            auto_crossover_en_reg <= strap_sync_reg;
        end
    end

    // no check against auto-negotiation here; software keeps the two consistent
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            force_crossover_reg <= 1'b0;
        end else if (wr_tc) begin
            force_crossover_reg <= reg_wdata_i[plbc_pkg::TC_FORCE_XOVER_BIT];
        end
    end

    assign auto_crossover_en_o = auto_crossover_en_reg;
    assign force_crossover_o = force_crossover_reg;

    // ****************************************
    // pause resolution
    // ****************************************
    always_comb begin
        pause_rx_next = an_full_duplex_i && local_pause_adv_i[plbc_pkg::ADV_SYM_PAUSE_BIT]
                        && (partner_pause_adv_i[plbc_pkg::ADV_SYM_PAUSE_BIT]
                            || (local_pause_adv_i[plbc_pkg::ADV_ASYM_DIR_BIT]
                                && partner_pause_adv_i[plbc_pkg::ADV_ASYM_DIR_BIT]));
        pause_tx_next = an_full_duplex_i && partner_pause_adv_i[plbc_pkg::ADV_SYM_PAUSE_BIT]
                        && (local_pause_adv_i[plbc_pkg::ADV_SYM_PAUSE_BIT]
                            || (local_pause_adv_i[plbc_pkg::ADV_ASYM_DIR_BIT]
                                && partner_pause_adv_i[plbc_pkg::ADV_ASYM_DIR_BIT]));
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pause_rx_reg <= 1'b0;
            pause_tx_reg <= 1'b0;
        end else begin
            pause_rx_reg <= pause_rx_next;
            pause_tx_reg <= pause_tx_next;
        end
    end

    assign pause_rx_en_o = pause_rx_reg;
    assign pause_tx_en_o = pause_tx_reg;

    // ****************************************
    // self-test control
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_reg <= 1'b0;
            seq_sel_reg <= 1'b0;
            bypass_reg <= 1'b0;
        end else if (wr_tc) begin
            run_reg <= reg_wdata_i[plbc_pkg::TC_RUN_BIT];
            seq_sel_reg <= reg_wdata_i[plbc_pkg::TC_SEQ_SEL_BIT];
            bypass_reg <= reg_wdata_i[plbc_pkg::TC_STRETCH_BYP_BIT];
        end
    end

    // the bit itself is the one-cycle error strobe, so one write gives exactly one error
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            inject_reg <= 1'b0;
        end else begin
            inject_reg <= wr_tc && reg_wdata_i[plbc_pkg::TC_INJECT_ERR_BIT];
        end
    end

    // only the fail latch lives here; error counting belongs to the diagnostic register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fail_reg <= 1'b0;
        end else if (!run_reg) begin
            fail_reg <= 1'b0;
        end else if (selftest_error_i) begin
            fail_reg <= 1'b1;
        end
    end

    assign pass_flag = run_reg && !fail_reg;
    assign selftest_run_o = run_reg;
    assign selftest_sequence_select_o = seq_sel_reg;
    assign selftest_inject_error_o = inject_reg;

    // ****************************************
    // register read
    // ****************************************
    always_comb begin
        led_word = plbc_pkg::REG_ZERO;
        led_word[plbc_pkg::LOC_SPEED_EN_BIT] = led_en_reg[2];
        led_word[plbc_pkg::LOC_LINK_EN_BIT] = led_en_reg[1];
        led_word[plbc_pkg::LOC_ACT_EN_BIT] = led_en_reg[0];
        led_word[plbc_pkg::LOC_SPEED_VAL_BIT] = led_val_reg[2];
        led_word[plbc_pkg::LOC_LINK_VAL_BIT] = led_val_reg[1];
        led_word[plbc_pkg::LOC_ACT_VAL_BIT] = led_val_reg[0];
        tc_word = plbc_pkg::REG_ZERO;
        tc_word[plbc_pkg::TC_AUTO_XOVER_BIT] = auto_crossover_en_reg;
        tc_word[plbc_pkg::TC_FORCE_XOVER_BIT] = force_crossover_reg;
        tc_word[plbc_pkg::TC_PAUSE_RX_BIT] = pause_rx_reg;
        tc_word[plbc_pkg::TC_PAUSE_TX_BIT] = pause_tx_reg;
        tc_word[plbc_pkg::TC_INJECT_ERR_BIT] = inject_reg;
        tc_word[plbc_pkg::TC_SEQ_SEL_BIT] = seq_sel_reg;
        tc_word[plbc_pkg::TC_PASS_BIT] = pass_flag;
        tc_word[plbc_pkg::TC_RUN_BIT] = run_reg;
        tc_word[plbc_pkg::TC_STRETCH_BYP_BIT] = bypass_reg;
        case (reg_addr_i)
            plbc_pkg::LED_OVERRIDE_CONTROL_ADDR: begin
                rdata_next = led_word;
            end
            plbc_pkg::TRANSCEIVER_CONTROL_ADDR: begin
                rdata_next = tc_word;
            end
            default: begin
                rdata_next = plbc_pkg::REG_ZERO;
            end
        endcase
    end

    // read data holds until the next read
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= plbc_pkg::REG_ZERO;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end
    end

endmodule // plbc_led_xover_bist_regs

// [plbc_led_xover_bist_regs_assertions.sv]
// concurrent checks on the ports of the led, crossover and self-test control bank
`timescale 1ns/10ps
module plbc_led_xover_bist_regs_assertions (
    // clock, reset and register port
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // leds, pause and controls
    input wire logic speed_led_out_o,
    input wire logic link_led_out_o,
    input wire logic activity_collision_led_out_o,
    input wire logic [1:0] local_pause_adv_i,
    input wire logic [1:0] partner_pause_adv_i,
    input wire logic an_full_duplex_i,
    input wire logic auto_crossover_en_o,
    input wire logic force_crossover_o,
    input wire logic selftest_run_o,
    input wire logic selftest_sequence_select_o,
    input wire logic selftest_inject_error_o,
    input wire logic pause_rx_en_o,
    input wire logic pause_tx_en_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic w18;
    logic w19;
    logic [1:0] lp;
    logic [1:0] pp;
    assign w18 = reg_wr_i && (reg_addr_i == plbc_pkg::LED_OVERRIDE_CONTROL_ADDR);
    assign w19 = reg_wr_i && (reg_addr_i == plbc_pkg::TRANSCEIVER_CONTROL_ADDR);
    assign lp = local_pause_adv_i;
    assign pp = partner_pause_adv_i;
    speed_force_a: assert property ((w18 && reg_wdata_i[5]) ##1 !w18
        |=> speed_led_out_o == $past(reg_wdata_i[2], 2)) else $error("speed led not forced");
    link_force_a: assert property ((w18 && reg_wdata_i[4]) ##1 !w18
        |=> link_led_out_o == $past(reg_wdata_i[1], 2)) else $error("link led not forced");
    act_force_a: assert property ((w18 && reg_wdata_i[3]) ##1 !w18
        |=> activity_collision_led_out_o == $past(reg_wdata_i[0], 2)) else $error("activity led not forced");
    inject_pulse_a: assert property (w19 && reg_wdata_i[11]
        |=> selftest_inject_error_o ##1 !selftest_inject_error_o) else $error("inject pulse wrong");
    run_select_a: assert property (w19 |=> selftest_run_o == $past(reg_wdata_i[8])
        && selftest_sequence_select_o == $past(reg_wdata_i[10])) else $error("run or select wrong");
    xover_ctrl_a: assert property (w19 |=> force_crossover_o == $past(reg_wdata_i[14])
        && auto_crossover_en_o == $past(reg_wdata_i[15])) else $error("crossover control wrong");
    pause_rx_a: assert property ($past(rst_n_i) |-> pause_rx_en_o ==
        $past(an_full_duplex_i & lp[0] & (pp[0] | (lp[1] & pp[1])))) else $error("pause rx wrong");
    pause_tx_a: assert property ($past(rst_n_i) |-> pause_tx_en_o ==
        $past(an_full_duplex_i & pp[0] & (lp[0] | (lp[1] & pp[1])))) else $error("pause tx wrong");
    led_upper_zero_a: assert property (reg_rd_i && reg_addr_i == plbc_pkg::LED_OVERRIDE_CONTROL_ADDR
        |=> reg_rdata_o[15:6] == 10'h000) else $error("led upper bits not zero");
    rdata_holds_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    stopped_pass_a: assert property (reg_rd_i && !selftest_run_o && w19 == 1'b0
        && reg_addr_i == plbc_pkg::TRANSCEIVER_CONTROL_ADDR |=> !reg_rdata_o[9]) else $error("pass while stopped");
endmodule // plbc_led_xover_bist_regs_assertions

bind plbc_led_xover_bist_regs plbc_led_xover_bist_regs_assertions plbc_led_xover_bist_regs_assertions_inst (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .speed_led_out_o(speed_led_out_o), .link_led_out_o(link_led_out_o),
    .activity_collision_led_out_o(activity_collision_led_out_o), .local_pause_adv_i(local_pause_adv_i),
    .partner_pause_adv_i(partner_pause_adv_i), .an_full_duplex_i(an_full_duplex_i),
    .auto_crossover_en_o(auto_crossover_en_o), .force_crossover_o(force_crossover_o),
    .selftest_run_o(selftest_run_o), .selftest_sequence_select_o(selftest_sequence_select_o),
    .selftest_inject_error_o(selftest_inject_error_o), .pause_rx_en_o(pause_rx_en_o),
    .pause_tx_en_o(pause_tx_en_o));

// [plbc_station_model.sv]
// station manager model issuing single-word register accesses
`timescale 1ns/10ps
module plbc_station_model (
    // clock and software state
    input wire logic sys_clk_i,
    input wire logic an_enable_i,
    // register port
    input wire logic [15:0] reg_rdata_i,
    output logic [4:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [15:0] reg_wdata_o,
    output logic reg_rd_o
);
    initial begin
        reg_addr_o = 5'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 16'h0000;
    end
    // each access first lets one edge pass, so a back-to-back call never re-raises a strobe it just lowered
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wr_o = 1'b1;
        // software keeps auto crossover off while auto-negotiation is off
        reg_wdata_o = (a == plbc_pkg::TRANSCEIVER_CONTROL_ADDR && !an_enable_i) ? (d & 16'h7FFF) : d;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
        // released data carries junk, never the last word
        reg_wdata_o = ~reg_wdata_o;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        d = reg_rdata_i;
    endtask
endmodule // plbc_station_model

// [tb_plbc_led_xover_bist_regs.sv]
// self-checking bench for the led, crossover and self-test control bank
`timescale 1ns/10ps
module tb_plbc_led_xover_bist_regs;
    logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, fd = 1'b0, serr = 1'b0, an_en = 1'b1;
    logic [1:0] lpa = 2'h0, ppa = 2'h0;
    plbc_pkg::plbc_led_t led_n = 3'h0;
    logic [15:0] rd, wd, lfsr = 16'hBD39, rdata, wdata;
    logic [4:0] addr;
    logic wr, rs, spd, lnk, act, axo, fxo, run, seq, inj, prx, ptx;
    int err_count = 0, samples_checked = 0, k;
    initial forever #25 clk = ~clk;
    plbc_station_model plbc_station_model_inst (.sys_clk_i(clk), .an_enable_i(an_en), .reg_rdata_i(rdata),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rs));
    plbc_led_xover_bist_regs #(.STRETCH_CYCLES(8)) plbc_led_xover_bist_regs_inst (.sys_clk_i(clk),
        .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rs),
        .reg_rdata_o(rdata), .auto_crossover_strap_i(strap), .led_normal_i(led_n), .speed_led_out_o(spd),
        .link_led_out_o(lnk), .activity_collision_led_out_o(act), .local_pause_adv_i(lpa),
        .partner_pause_adv_i(ppa), .an_full_duplex_i(fd), .auto_crossover_en_o(axo), .force_crossover_o(fxo),
        .selftest_error_i(serr), .selftest_run_o(run), .selftest_sequence_select_o(seq),
        .selftest_inject_error_o(inj), .pause_rx_en_o(prx), .pause_tx_en_o(ptx));
    function automatic logic [15:0] nxt();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    function automatic logic [2:0] led_exp(logic [15:0] d, logic [2:0] n);
        return {d[5] ? d[2] : n[2], d[4] ? d[1] : n[1], d[3] ? d[0] : n[0]};
    endfunction
    function automatic logic [1:0] pause_exp(logic f, logic [1:0] l, logic [1:0] p);
        return {f & l[0] & (p[0] | (l[1] & p[1])), f & p[0] & (l[0] | (l[1] & p[1]))};
    endfunction
    task automatic check(logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checked %0d values, %0d mismatches", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk);
    endtask
    // ****************************************
    // watchdog
    // ****************************************
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        close_out();
    end
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        tick(8);
        rst_n = 1'b1;
        tick(6);
        plbc_station_model_inst.rd(5'h19, rd); check(rd, 16'h8000);
        plbc_station_model_inst.rd(5'h18, rd); check(rd, 16'h0000);
        plbc_station_model_inst.rd(5'h03, rd); check(rd, 16'h0000);
        plbc_station_model_inst.wr(5'h19, 16'h0080);
        for (int i = 0; i < 24; i++) begin
            wd = nxt();
            led_n = wd[15:13];
            plbc_station_model_inst.wr(5'h18, wd);
            tick(2);
            check({13'h0, spd, lnk, act}, {13'h0, led_exp(wd, led_n)});
            plbc_station_model_inst.rd(5'h18, rd); check(rd, wd & 16'h003F);
        end
        // stretched speed indication outlives a short pulse
        plbc_station_model_inst.wr(5'h18, 16'h0000);
        plbc_station_model_inst.wr(5'h19, 16'h0000);
        led_n = 3'h4;
        tick(3);
        led_n = 3'h0;
        tick(4);
        check({15'h0, spd}, 16'h0001);
        k = 0;
        while (spd !== 1'b0 && k < 12) begin
            k++;
            tick(1);
        end
        check({15'h0, spd}, 16'h0000);
        check(16'(k), 16'h0006);
        for (int i = 0; i < 32; i++) begin
            {fd, lpa, ppa} = i[4:0];
            tick(2);
            check({14'h0, prx, ptx}, {14'h0, pause_exp(fd, lpa, ppa)});
            plbc_station_model_inst.rd(5'h19, rd); check({14'h0, rd[13:12]}, {14'h0, pause_exp(fd, lpa, ppa)});
        end
        fd = 1'b0;
        plbc_station_model_inst.wr(5'h19, 16'hC000);
        check({14'h0, axo, fxo}, 16'h0003);
        an_en = 1'b0;
        plbc_station_model_inst.wr(5'h19, 16'hC000);
        check({14'h0, axo, fxo}, 16'h0001);
        plbc_station_model_inst.wr(5'h19, 16'h0500);
        plbc_station_model_inst.rd(5'h19, rd); check(rd, 16'h0700);
        check({14'h0, run, seq}, 16'h0003);
        serr = 1'b1;
        tick(1);
        serr = 1'b0;
        tick(3);
        plbc_station_model_inst.rd(5'h19, rd); check(rd, 16'h0500);
        plbc_station_model_inst.wr(5'h19, 16'h0D00);
        check({15'h0, inj}, 16'h0001);
        tick(1);
        check({15'h0, inj}, 16'h0000);
        plbc_station_model_inst.rd(5'h19, rd); check(rd, 16'h0500);
        plbc_station_model_inst.wr(5'h19, 16'h0000);
        plbc_station_model_inst.rd(5'h19, rd); check(rd, 16'h0000);
        plbc_station_model_inst.wr(5'h19, 16'h0100);
        plbc_station_model_inst.rd(5'h19, rd); check(rd, 16'h0300);
        // mid-run reset with the strap low: running test and crossover must come back cleared
        strap = 1'b0;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(6);
        plbc_station_model_inst.rd(5'h19, rd); check(rd, 16'h0000);
        check({14'h0, run, axo}, 16'h0000);
        close_out();
    end
endmodule // tb_plbc_led_xover_bist_regs
